// File: hdl/touch_saver_pkg.sv
// Shared constants and types of the touch backlight saver block
package touch_saver_pkg;

  // APB byte addresses of the registers
  localparam logic [7:0] AUX_MODE_CONFIG_OFS = 8'h1C;
  localparam logic [7:0] WAKE_BRIGHTNESS_OFS = 8'h20;
  localparam logic [7:0] IDLE_BRIGHTNESS_OFS = 8'h24;
  localparam logic [7:0] IDLE_DELAY_SECONDS_OFS = 8'h28;
  localparam logic [7:0] WORK_MODE_CONFIG_ONE_OFS = 8'h2C;
  localparam logic [7:0] BUZZER_CTL_OFS = 8'h30;
  localparam logic [7:0] SAVER_STATUS_OFS = 8'h34;

  // Field positions
  localparam int unsigned CLICK_TONE_DISABLE_BIT = 5;
  localparam int unsigned PAGE_VARIABLE_COUNT_SEL_BIT = 4;
  localparam int unsigned CRC_REPLY_ENABLE_BIT = 3;
  localparam int unsigned TOUCH_CALIBRATION_SEL_BIT = 2;
  localparam int unsigned SAVER_ENABLE_BIT = 5;
  localparam int unsigned BUZZER_ON_BIT = 0;
  localparam int unsigned STATUS_DIMMED_BIT = 7;

  // Values after reset
  localparam logic [7:0] AUX_MODE_CONFIG_RST = 8'h00;
  localparam logic [7:0] WAKE_BRIGHTNESS_RST = 8'h40;
  localparam logic [7:0] IDLE_BRIGHTNESS_RST = 8'h10;
  localparam logic [7:0] IDLE_DELAY_SECONDS_RST = 8'h1E;
  localparam logic [7:0] WORK_MODE_CONFIG_ONE_RST = 8'h00;
  localparam logic [7:0] BUZZER_CTL_RST = 8'h00;

  // Brightness scale: code 0x40 is full backlight
  localparam logic [6:0] BRIGHT_FULL = 7'h40;
  localparam logic [7:0] VARS_PER_PAGE_64 = 8'h40;

  // Timing
  localparam int unsigned CLK_FREQ_KHZ = 40000;
  localparam int unsigned IDLE_UNIT_S = 1;
  localparam int unsigned IDLE_UNIT_CYC = CLK_FREQ_KHZ * 1000 * IDLE_UNIT_S;
  localparam int unsigned BEEP_MS = 50;
  localparam int unsigned BEEP_CYC = CLK_FREQ_KHZ * BEEP_MS;

  // Backlight control states
  typedef enum logic [1:0] {ST_FIXED, ST_AWAKE, ST_DIMMED} saver_state_t;

endpackage : touch_saver_pkg

// File: hdl/saver_if.sv
// Control bundle between the saver core, its idle timer and its PWM stage
`timescale 1ns/1ps
interface saver_if;
  logic restart;
  logic enable;
  logic [7:0] delay;
  logic expired;
  logic [6:0] level;

  modport core (output restart, output enable, output delay, output level, input expired);
  modport timer (input restart, input enable, input delay, output expired);
  modport pwm (input level);
endinterface : saver_if

// File: hdl/idle_timer.sv
// Idle-second counter of the screen saver
`timescale 1ns/1ps
module idle_timer
  import touch_saver_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = IDLE_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control bundle
  saver_if.timer ctl
);

  logic [31:0] tick_q;
  logic [7:0] sec_q;
  logic expired_q;
  wire [7:0] limit = (ctl.delay == 8'h00) ? 8'h01 : ctl.delay;
  wire tick_wrap = (tick_q == 32'(TICKS_PER_SEC - 1));
  wire [7:0] sec_next = sec_q + 8'h01;

  // Whole seconds counted only while the core keeps the timer enabled
  always_ff @(posedge clk_i) begin
    if (srst_i || ctl.restart || !ctl.enable) begin
      tick_q <= 32'h0000_0000;
      sec_q <= 8'h00;
      expired_q <= 1'b0;
    end else if (!expired_q) begin
      if (tick_wrap) begin
        tick_q <= 32'h0000_0000;
        sec_q <= sec_next;
        expired_q <= (sec_next == limit);
      end else begin
        tick_q <= tick_q + 32'h0000_0001;
      end
    end
  end

  assign ctl.expired = expired_q;

  AST_IDLE_RESTART: assert property (@(posedge clk_i) disable iff (srst_i)
    ctl.restart |=> !expired_q && sec_q == 8'h00)
    else $error("idle timer not restarted by touch");

  AST_IDLE_AT_LIMIT: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(expired_q) |-> $past(tick_wrap) && sec_q == $past(limit))
    else $error("idle expiry not at programmed seconds");

endmodule : idle_timer

// File: hdl/backlight_pwm.sv
// Linear PWM stage turning a brightness code into backlight duty
`timescale 1ns/1ps
module backlight_pwm
  import touch_saver_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control bundle
  saver_if.pwm ctl,
  // Backlight drive
  output logic pwm_o
);

  logic [5:0] phase_q;
  logic pwm_q;
  // Sixty-four slots, so code 0x40 stays high and 0x10 is a quarter duty
  wire pwm_d = ({1'b0, phase_q} < ctl.level);

  // Free-running phase and registered output
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_q <= 6'h00;
      pwm_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 6'h01;
      pwm_q <= pwm_d;
    end
  end

  assign pwm_o = pwm_q;

  AST_PWM_FULL: assert property (@(posedge clk_i) disable iff (srst_i)
    (ctl.level == BRIGHT_FULL) |=> pwm_q)
    else $error("full code did not give full backlight");

  AST_PWM_QUARTER: assert property (@(posedge clk_i) disable iff (srst_i)
    (ctl.level == 7'h10 && phase_q == 6'h10) |=> !pwm_q)
    else $error("quarter code exceeded quarter duty");

endmodule : backlight_pwm

// File: hdl/touch_backlight_saver_cfg.sv
// Top of the touch backlight saver: APB registers, touch handling, buzzer and CRC reply
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
// How it works
// - With click tone enabled, an active-area touch sounds the buzzer, except a touch that wakes from dimmed.
// - With click tone disabled, buzzer follows only the host buzzer register.
// - Page-size bit zero gives 64 variables per page; one is undefined.
// - CRC check result reply is sent only when the acknowledge bit is set.
// - Saver enable bit lets touch activity govern the backlight level.
// - First touch while dimmed only wakes; no control action is issued.
// - A touch with saver enabled restores the working brightness code.
// - After the programmed idle delay the backlight drops to saver brightness.
// - Idle delay counts whole seconds, one to 255.
// - Brightness codes scale linearly, 0x40 full and 0x10 one quarter.
module touch_backlight_saver_cfg
  import touch_saver_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = IDLE_UNIT_CYC,
  parameter int unsigned BEEP_CYCLES = BEEP_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Touch panel pins
  input wire logic TOUCH_PRESS_I,
  input wire logic TOUCH_IN_ACTIVE_AREA_I,
  // CRC checker of the serial framing
  input wire logic CRC_CHECK_DONE_I,
  input wire logic CRC_CHECK_OK_I,
  // Outputs
  output logic BUZZER_O,
  output logic BACKLIGHT_PWM_O,
  output logic [6:0] BACKLIGHT_LEVEL_O,
  output logic TOUCH_ACTION_O,
  output logic CRC_REPLY_REQ_O,
  output logic CRC_REPLY_OK_O,
  output logic [7:0] VARS_PER_PAGE_O
);

  saver_if sv ();

  // Registers
  logic [7:0] aux_mode_config_q;
  logic [7:0] wake_brightness_q;
  logic [7:0] idle_brightness_q;
  logic [7:0] idle_delay_seconds_q;
  logic [7:0] work_mode_config_one_q;
  logic [7:0] buzzer_ctl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Touch synchroniser and edge
  logic press_meta_q;
  logic press_sync_q;
  logic press_prev_q;
  logic area_meta_q;
  logic area_sync_q;

  // Core state
  saver_state_t state_q;
  saver_state_t state_d;
  logic [6:0] level_q;
  logic action_q;
  logic [31:0] beep_cnt_q;
  logic buzzer_q;
  logic crc_req_q;
  logic crc_ok_q;
  logic [7:0] vars_q;

  // APB decode
  wire apb_access = PSEL_I && PENABLE_I && !pready_q;
  wire apb_done = PSEL_I && PENABLE_I && pready_q;
  wire hit_aux = (PADDR_I == AUX_MODE_CONFIG_OFS);
  wire hit_wake = (PADDR_I == WAKE_BRIGHTNESS_OFS);
  wire hit_idle = (PADDR_I == IDLE_BRIGHTNESS_OFS);
  wire hit_delay = (PADDR_I == IDLE_DELAY_SECONDS_OFS);
  wire hit_mode = (PADDR_I == WORK_MODE_CONFIG_ONE_OFS);
  wire hit_buzz = (PADDR_I == BUZZER_CTL_OFS);
  wire hit_stat = (PADDR_I == SAVER_STATUS_OFS);
  wire hit_any = hit_aux || hit_wake || hit_idle || hit_delay || hit_mode || hit_buzz
                 || hit_stat;
  wire wr_en = apb_done && PWRITE_I;
  wire [7:0] status_val = {state_q == ST_DIMMED, level_q};
  wire [7:0] rd_byte = hit_aux ? aux_mode_config_q :
                       hit_wake ? wake_brightness_q :
                       hit_idle ? idle_brightness_q :
                       hit_delay ? idle_delay_seconds_q :
                       hit_mode ? work_mode_config_one_q :
                       hit_buzz ? buzzer_ctl_q :
                       hit_stat ? status_val : 8'h00;

  // Writes take effect on the completing access edge only
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      aux_mode_config_q <= AUX_MODE_CONFIG_RST;
      wake_brightness_q <= WAKE_BRIGHTNESS_RST;
      idle_brightness_q <= IDLE_BRIGHTNESS_RST;
      idle_delay_seconds_q <= IDLE_DELAY_SECONDS_RST;
      work_mode_config_one_q <= WORK_MODE_CONFIG_ONE_RST;
      buzzer_ctl_q <= BUZZER_CTL_RST;
    end else if (wr_en) begin
      if (hit_aux) aux_mode_config_q <= PWDATA_I[7:0]; // Reserved bits kept as written
      if (hit_wake) wake_brightness_q <= PWDATA_I[7:0];
      if (hit_idle) idle_brightness_q <= PWDATA_I[7:0];
      if (hit_delay) idle_delay_seconds_q <= PWDATA_I[7:0];
      if (hit_mode) work_mode_config_one_q <= PWDATA_I[7:0];
      if (hit_buzz) buzzer_ctl_q <= PWDATA_I[7:0];
    end
  end

  // One wait state: ready and read data rise together
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_access;
      pslverr_q <= apb_access && !(hit_any && !(PWRITE_I && hit_stat));
      prdata_q <= (apb_access && !PWRITE_I) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Touch pins cross in through two flops each
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      press_meta_q <= 1'b0;
      press_sync_q <= 1'b0;
      press_prev_q <= 1'b0;
      area_meta_q <= 1'b0;
      area_sync_q <= 1'b0;
    end else begin
      press_meta_q <= TOUCH_PRESS_I;
      press_sync_q <= press_meta_q;
      press_prev_q <= press_sync_q;
      area_meta_q <= TOUCH_IN_ACTIVE_AREA_I;
      area_sync_q <= area_meta_q;
    end
  end

  // Mode decode
  wire touch_edge = press_sync_q && !press_prev_q;
  wire saver_en = work_mode_config_one_q[SAVER_ENABLE_BIT];
  wire tone_off = aux_mode_config_q[CLICK_TONE_DISABLE_BIT];
  wire crc_ack_en = aux_mode_config_q[CRC_REPLY_ENABLE_BIT];
  wire page_sel = aux_mode_config_q[PAGE_VARIABLE_COUNT_SEL_BIT];
  // Codes above full scale would overdrive the PWM, so they clamp
  wire [6:0] wake_clamp = (wake_brightness_q > {1'b0, BRIGHT_FULL}) ? BRIGHT_FULL :
                          wake_brightness_q[6:0];
  wire [6:0] idle_clamp = (idle_brightness_q > {1'b0, BRIGHT_FULL}) ? BRIGHT_FULL :
                          idle_brightness_q[6:0];

  // Backlight state transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_FIXED: begin
        if (saver_en) state_d = ST_AWAKE;
      end
      ST_AWAKE: begin
        if (!saver_en) state_d = ST_FIXED;
        else if (sv.expired && !touch_edge) state_d = ST_DIMMED;
      end
      ST_DIMMED: begin
        if (!saver_en) state_d = ST_FIXED;
        else if (touch_edge) state_d = ST_AWAKE;
      end
      default: state_d = ST_FIXED;
    endcase
  end

  // Timer steering
  assign sv.restart = touch_edge;
  assign sv.enable = (state_q == ST_AWAKE);
  assign sv.delay = idle_delay_seconds_q;
  assign sv.level = level_q;

  // Level, action and page size registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_q <= ST_FIXED;
      level_q <= 7'h00;
      action_q <= 1'b0;
      vars_q <= 8'h00;
    end else begin
      state_q <= state_d;
      level_q <= (state_q == ST_DIMMED) ? idle_clamp : wake_clamp;
      action_q <= touch_edge && (state_q != ST_DIMMED);
      vars_q <= page_sel ? VARS_PER_PAGE_64 : VARS_PER_PAGE_64; // Undefined code kept safe
    end
  end

  // Click tone and host buzzer
  wire beep_start = touch_edge && area_sync_q && (state_q != ST_DIMMED) && !tone_off;
  wire beep_busy = (beep_cnt_q != 32'h0000_0000);
  wire host_buzz = buzzer_ctl_q[BUZZER_ON_BIT];

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      beep_cnt_q <= 32'h0000_0000;
      buzzer_q <= 1'b0;
    end else begin
      if (tone_off) beep_cnt_q <= 32'h0000_0000;
      else if (beep_start) beep_cnt_q <= 32'(BEEP_CYCLES);
      else if (beep_busy) beep_cnt_q <= beep_cnt_q - 32'h0000_0001;
      buzzer_q <= tone_off ? host_buzz : (beep_start || beep_busy || host_buzz);
    end
  end

  // CRC result reply gating
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      crc_req_q <= 1'b0;
      crc_ok_q <= 1'b0;
    end else begin
      crc_req_q <= CRC_CHECK_DONE_I && crc_ack_en;
      if (CRC_CHECK_DONE_I) crc_ok_q <= CRC_CHECK_OK_I;
    end
  end

  idle_timer #(
    .TICKS_PER_SEC(TICKS_PER_SEC)
  ) u_idle_timer (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .ctl(sv.timer)
  );

  backlight_pwm u_backlight_pwm (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .ctl(sv.pwm),
    .pwm_o(BACKLIGHT_PWM_O)
  );

  // Outputs straight from flops
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign BUZZER_O = buzzer_q;
  assign BACKLIGHT_LEVEL_O = level_q;
  assign TOUCH_ACTION_O = action_q;
  assign CRC_REPLY_REQ_O = crc_req_q;
  assign CRC_REPLY_OK_O = crc_ok_q;
  assign VARS_PER_PAGE_O = vars_q;

  AST_TONE_BEEP: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    beep_start |=> buzzer_q && beep_cnt_q == 32'(BEEP_CYCLES))
    else $error("touch tone missing");

  AST_TONE_MUTED: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (tone_off && !host_buzz) |=> !buzzer_q)
    else $error("buzzer sounded while tone disabled");

  AST_HOST_BUZZ: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (tone_off && host_buzz) |=> buzzer_q)
    else $error("host buzzer data ignored");

  AST_PAGE_64: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !page_sel |=> vars_q == 8'h40)
    else $error("page variable count not 64");

  AST_CRC_REPLY: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    CRC_CHECK_DONE_I |=> crc_req_q == $past(crc_ack_en))
    else $error("crc reply gating wrong");

  AST_SAVER_OFF: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !saver_en |=> state_q == ST_FIXED ##1 level_q == $past(wake_clamp))
    else $error("fixed level not kept with saver off");

  AST_WAKE_NO_ACTION: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (state_q == ST_DIMMED && touch_edge) |=> !action_q)
    else $error("wake touch issued an action");

  AST_WAKE_LEVEL: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (state_q == ST_DIMMED && touch_edge && saver_en) |=> state_q == ST_AWAKE ##1
      level_q == $past(wake_clamp))
    else $error("touch did not restore working brightness");

  AST_DIM_LEVEL: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (state_q == ST_AWAKE && saver_en && sv.expired && !touch_edge) |=> ##1
      level_q == $past(idle_clamp))
    else $error("saver brightness not applied after idle delay");

  AST_TOUCH_ACTION: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (touch_edge && state_q == ST_AWAKE) |=> action_q && !sv.expired)
    else $error("awake touch lost or timer not restarted");

endmodule : touch_backlight_saver_cfg

// File: sim/touch_user_model.sv
// Touch panel user model: presses the panel for a while on request
`timescale 1ns/1ps
module touch_user_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the bench
  input wire logic tap_i,
  input wire logic area_i,
  // Panel pins
  output logic press_o,
  output logic area_o
);
  logic [3:0] hold_q;
  logic area_q;

  // Hold each press eight cycles so the two-flop synchroniser sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 4'h0;
      area_q <= 1'b0;
    end else if (tap_i) begin
      hold_q <= 4'h8;
      area_q <= area_i;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end

  // Area line means nothing when released: show the inverse, not a stale value
  assign press_o = (hold_q != 4'h0);
  assign area_o = press_o ? area_q : ~area_q;
endmodule : touch_user_model

// File: sim/tb_touch_backlight_saver_cfg.sv
// Self-checking bench of the touch backlight saver block
`timescale 1ns/1ps
module tb_touch_backlight_saver_cfg;
  import touch_saver_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic crc_done = 1'b0, crc_ok = 1'b0, tap_r = 1'b0, area_r = 1'b0;
  logic press, area, err, act, bz;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, buzzer, pwm, action, crc_req, crc_res;
  wire logic [6:0] level;
  wire logic [7:0] vars;
  int errors = 0, num_checks = 0, n;

  // 25 ns period clock
  always #12.5 clk = ~clk;

  touch_user_model user (.clk_i(clk), .rst_i(srst), .tap_i(tap_r), .area_i(area_r),
    .press_o(press), .area_o(area));

  touch_backlight_saver_cfg #(.TICKS_PER_SEC(10), .BEEP_CYCLES(5)) uut (
    .CORE_CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TOUCH_PRESS_I(press), .TOUCH_IN_ACTIVE_AREA_I(area),
    .CRC_CHECK_DONE_I(crc_done), .CRC_CHECK_OK_I(crc_ok), .BUZZER_O(buzzer),
    .BACKLIGHT_PWM_O(pwm), .BACKLIGHT_LEVEL_O(level), .TOUCH_ACTION_O(action),
    .CRC_REPLY_REQ_O(crc_req), .CRC_REPLY_OK_O(crc_res), .VARS_PER_PAGE_O(vars));

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // APB transfer; ready, data and error are taken at the rising edge that completes it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // One press; records any action pulse and any buzzer activity
  task automatic tap(input logic a);
    act = 1'b0;
    bz = 1'b0;
    @(posedge clk);
    tap_r <= 1'b1; area_r <= a;
    @(posedge clk);
    tap_r <= 1'b0;
    repeat (14) begin
      @(negedge clk);
      act = act | (action === 1'b1);
      bz = bz | (buzzer === 1'b1);
    end
  endtask : tap

  // Bounded wait for an applied brightness code; n holds cycles waited
  task automatic wait_level(input logic [6:0] exp, input int max);
    n = 0;
    while (level !== exp && n < max) begin
      @(negedge clk);
      n++;
    end
    chk("level", {25'h0, exp}, {25'h0, level});
    if (n >= max) test_done();
  endtask : wait_level

  // High cycles of the backlight over one 64-cycle period
  task automatic duty(input int exp);
    int h;
    h = 0;
    repeat (64) begin
      @(negedge clk);
      h += (pwm === 1'b1);
    end
    chk("pwm duty", exp, h);
  endtask : duty

  task automatic t_regs();
    apb(1'b0, AUX_MODE_CONFIG_OFS, 32'h0);
    chk("aux reset", {24'h0, AUX_MODE_CONFIG_RST}, rd);
    apb(1'b0, WAKE_BRIGHTNESS_OFS, 32'h0);
    chk("wake reset", {24'h0, WAKE_BRIGHTNESS_RST}, rd);
    apb(1'b0, IDLE_BRIGHTNESS_OFS, 32'h0);
    chk("idle reset", {24'h0, IDLE_BRIGHTNESS_RST}, rd);
    apb(1'b0, IDLE_DELAY_SECONDS_OFS, 32'h0);
    chk("delay reset", {24'h0, IDLE_DELAY_SECONDS_RST}, rd);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, SAVER_STATUS_OFS, 32'hFF);
    chk("status write err", 32'h1, {31'h0, err});
    chk("vars per page", 32'h40, {24'h0, vars});
  endtask : t_regs

  task automatic t_tone();
    apb(1'b1, AUX_MODE_CONFIG_OFS, 32'h0);
    tap(1'b1);
    chk("tone beep", 32'h3, {30'h0, act, bz});
    apb(1'b1, AUX_MODE_CONFIG_OFS, 32'h20);
    tap(1'b1);
    chk("muted beep", 32'h2, {30'h0, act, bz});
    // Register lands at the completing edge, the buzzer flop one edge later
    apb(1'b1, BUZZER_CTL_OFS, 32'h1);
    repeat (2) @(negedge clk);
    chk("host buzzer", 32'h1, {31'h0, buzzer});
    apb(1'b1, BUZZER_CTL_OFS, 32'h0);
    repeat (2) @(negedge clk);
    chk("host buzzer off", 32'h0, {31'h0, buzzer});
  endtask : t_tone

  // Result reply only with the acknowledge bit set
  task automatic t_crc(input logic [7:0] cfg, input logic ok);
    logic seen;
    seen = 1'b0;
    apb(1'b1, AUX_MODE_CONFIG_OFS, {24'h0, cfg});
    @(posedge clk);
    crc_done <= 1'b1; crc_ok <= ok;
    @(posedge clk);
    crc_done <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      seen = seen | (crc_req === 1'b1);
    end
    chk("crc reply", {31'h0, cfg[3]}, {31'h0, seen});
    chk("crc result", {31'h0, ok}, {31'h0, crc_res});
  endtask : t_crc

  task automatic t_saver();
    apb(1'b1, WAKE_BRIGHTNESS_OFS, 32'h30);
    apb(1'b1, IDLE_BRIGHTNESS_OFS, 32'h10);
    apb(1'b1, IDLE_DELAY_SECONDS_OFS, 32'h2);
    apb(1'b1, WORK_MODE_CONFIG_ONE_OFS, 32'h20);
    tap(1'b1);
    wait_level(7'h30, 10);
    // Second touch inside the idle window must restart the count
    repeat (4) @(negedge clk);
    tap(1'b1);
    wait_level(7'h10, 60);
    chk("idle span", 32'h1, {31'h0, (n >= 4 && n <= 12)});
    apb(1'b0, SAVER_STATUS_OFS, 32'h0);
    chk("status dimmed", 32'h90, rd);
    duty(16);
    tap(1'b1);
    chk("wake touch", 32'h0, {30'h0, act, bz});
    wait_level(7'h30, 10);
  endtask : t_saver

  task automatic t_fixed();
    apb(1'b1, WAKE_BRIGHTNESS_OFS, 32'h40);
    apb(1'b1, WORK_MODE_CONFIG_ONE_OFS, 32'h0);
    wait_level(7'h40, 10);
    repeat (40) @(negedge clk);
    chk("fixed level", 32'h40, {25'h0, level});
    duty(64);
  endtask : t_fixed

  // Bounded overall run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_tone();
    t_crc(8'h00, 1'b1);
    t_crc(8'h08, 1'b1);
    t_crc(8'h08, 1'b0);
    t_saver();
    t_fixed();
    test_done();
  end
endmodule : tb_touch_backlight_saver_cfg
